/* common/acc_defines.svh */
// Constants for the converter conversion control block
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_DATA_W        16
`define ACC_DATA_RST      16'h0000
`define ACC_CFG_W         8
`define ACC_CFG_RST       8'h00
`define ACC_CONV_NS       4000
`define ACC_CLK_NS        20
`define ACC_CONV_CYC      ((`ACC_CONV_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_CNT_W         8
`endif

/* common/acc_pkg.sv */
// Types for the converter conversion control block
package acc_pkg;
   typedef enum logic [1:0]
   {
      ACC_IDLE = 2'b00,
      ACC_CONV = 2'b01
   } acc_state_e;
   typedef enum logic [1:0]
   {
      ACC_RNG_0_5   = 2'b00,
      ACC_RNG_0_10  = 2'b01,
      ACC_RNG_PM5   = 2'b10,
      ACC_RNG_PM10  = 2'b11
   } acc_range_e;
endpackage

/* rtl/acc_conversion_control.sv */
// Digital control front of a 16-bit successive-approximation converter
`include "acc_defines.svh"
module acc_conversion_control
   import acc_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   input  wire logic                     reset_in,
   input  wire logic                     chip_select_n,
   input  wire logic                     read_n,
   input  wire logic                     power_down_in,
   input  wire logic                     conversion_start_n,
   input  wire logic                     output_coding_select,
   input  wire logic                     range_polarity_select,
   input  wire logic                     range_span_select,
   input  wire logic                     serial_mode,
   input  wire logic                     slave_sclk,
   input  wire logic                     cfg_sclk,
   input  wire logic                     cfg_sdin,
   input  wire logic [`ACC_DATA_W-1:0]   result_in,
   output logic      [`ACC_DATA_W-1:0]   data_out,
   output logic      [`ACC_DATA_W-1:0]   data_oe,
   output logic                          sample_hold,
   output logic                          busy,
   output logic                          powered_down,
   output logic                          slave_sclk_gated,
   output logic      [1:0]               input_range,
   output logic      [`ACC_CFG_W-1:0]    config_out
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] rst_s_q, cs_s_q, rd_s_q, pd_s_q, cnv_s_q, sclk_s_q, csclk_s_q, csd_s_q;
   logic       cnv_prev_q, sclk_prev_q, csclk_prev_q, rst_prev_q;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_s_q   <= 2'h0;
         cs_s_q    <= 2'h3;
         rd_s_q    <= 2'h3;
         pd_s_q    <= 2'h0;
         cnv_s_q   <= 2'h3;
         sclk_s_q  <= 2'h0;
         csclk_s_q <= 2'h0;
         csd_s_q   <= 2'h0;
      end
      else
      begin
         rst_s_q   <= {rst_s_q[0], reset_in};
         cs_s_q    <= {cs_s_q[0], chip_select_n};
         rd_s_q    <= {rd_s_q[0], read_n};
         pd_s_q    <= {pd_s_q[0], power_down_in};
         cnv_s_q   <= {cnv_s_q[0], conversion_start_n};
         sclk_s_q  <= {sclk_s_q[0], slave_sclk};
         csclk_s_q <= {csclk_s_q[0], cfg_sclk};
         csd_s_q   <= {csd_s_q[0], cfg_sdin};
      end
   end

   // ------------------------------------------------------------
   // Level pin synchronisers
   // ------------------------------------------------------------
   // Mode and range pins are quasi-static but still arrive from outside,
   // so they get the same two stages as the strobes
   logic [1:0] smode_s_q, coding_s_q, pol_s_q, span_s_q;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         smode_s_q  <= 2'h0;
         coding_s_q <= 2'h0;
         pol_s_q    <= 2'h0;
         span_s_q   <= 2'h0;
      end
      else
      begin
         smode_s_q  <= {smode_s_q[0], serial_mode};
         coding_s_q <= {coding_s_q[0], output_coding_select};
         pol_s_q    <= {pol_s_q[0], range_polarity_select};
         span_s_q   <= {span_s_q[0], range_span_select};
      end
   end

   wire smode_lvl  = smode_s_q[1];
   wire coding_lvl = coding_s_q[1];

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic in_conv(input acc_state_e st);
      return (st == ACC_CONV);
   endfunction

   wire rst_lvl  = rst_s_q[1];
   wire cs_lvl_n = cs_s_q[1];
   wire rd_lvl_n = rd_s_q[1];
   wire pd_lvl   = pd_s_q[1];
   wire cnv_fall = cnv_prev_q & ~cnv_s_q[1];
   wire rst_fall = rst_prev_q & ~rst_lvl;
   wire csclk_rise = ~csclk_prev_q & csclk_s_q[1];

   // ------------------------------------------------------------
   // Conversion sequencer
   // ------------------------------------------------------------
   acc_state_e                state_q, state_d;
   logic [`ACC_CNT_W-1:0]     cnt_q, cnt_d;
   logic [`ACC_DATA_W-1:0]    data_q, data_d;
   logic [`ACC_CFG_W-1:0]     cfg_q, cfg_d;

   wire start_ok = cnv_fall & ~pd_lvl & ~rst_lvl;
   wire conv_end = in_conv(state_q) && (cnt_q == `ACC_CNT_W'(`ACC_CONV_CYC - 1));

   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      unique case (state_q)
         ACC_IDLE:
         begin
            cnt_d = '0;
            if (start_ok)
               state_d = ACC_CONV;
         end
         ACC_CONV:
         begin
            // Power-down is not checked here: a started conversion runs out
            cnt_d = cnt_q + `ACC_CNT_W'(1);
            if (conv_end)
               state_d = ACC_IDLE;
         end
         default:
            state_d = ACC_IDLE;
      endcase
      if (rst_lvl)
      begin
         state_d = ACC_IDLE;
         cnt_d   = '0;
      end
   end

   // Coding select: high gives straight binary, low flips the sign bit
   wire [`ACC_DATA_W-1:0] coded = coding_lvl ? result_in :
                                  {~result_in[`ACC_DATA_W-1], result_in[`ACC_DATA_W-2:0]};

   always_comb
   begin
      data_d = data_q;
      if (rst_fall)
         data_d = `ACC_DATA_RST;
      else if (conv_end && !rst_lvl)
         data_d = coded;
   end

   // Write-only config port stays live in power-down and ignores select
   always_comb
   begin
      cfg_d = cfg_q;
      if (rst_fall || rst_lvl)
         cfg_d = `ACC_CFG_RST;
      else if (csclk_rise)
         cfg_d = {cfg_q[`ACC_CFG_W-2:0], csd_s_q[1]};
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q      <= ACC_IDLE;
         cnt_q        <= '0;
         data_q       <= `ACC_DATA_RST;
         cfg_q        <= `ACC_CFG_RST;
         cnv_prev_q   <= 1'b1;
         sclk_prev_q  <= 1'b0;
         csclk_prev_q <= 1'b0;
         rst_prev_q   <= 1'b0;
      end
      else
      begin
         state_q      <= state_d;
         cnt_q        <= cnt_d;
         data_q       <= data_d;
         cfg_q        <= cfg_d;
         cnv_prev_q   <= cnv_s_q[1];
         sclk_prev_q  <= sclk_s_q[1];
         csclk_prev_q <= csclk_s_q[1];
         rst_prev_q   <= rst_lvl;
      end
   end

   // ------------------------------------------------------------
   // Output bus and status
   // ------------------------------------------------------------
   // Bus is shared: release it whenever the host is not reading
   wire bus_en = ~cs_lvl_n & ~rd_lvl_n;

   assign data_out         = data_q;
   assign data_oe          = bus_en ? {`ACC_DATA_W{1'b1}} : {`ACC_DATA_W{1'b0}};
   assign sample_hold      = in_conv(state_q);
   assign busy             = in_conv(state_q);
   assign powered_down     = pd_lvl & ~in_conv(state_q);
   // Gating uses the synced select, so a select edge costs two clocks
   assign slave_sclk_gated = smode_lvl & ~cs_lvl_n & sclk_s_q[1] & ~sclk_prev_q;
   assign input_range      = {pol_s_q[1], span_s_q[1]};
   assign config_out       = cfg_q;
endmodule

/* tb/acc_checker.sv */
// Port assertions for the conversion control block
`include "acc_defines.svh"
module acc_checker (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        reset_in,
   input wire logic        chip_select_n,
   input wire logic        read_n,
   input wire logic        power_down_in,
   input wire logic        conversion_start_n,
   input wire logic        serial_mode,
   input wire logic        range_polarity_select,
   input wire logic        range_span_select,
   input wire logic        busy,
   input wire logic        slave_sclk_gated,
   input wire logic [1:0]  input_range,
   input wire logic [7:0]  config_out,
   input wire logic [15:0] data_out,
   input wire logic [15:0] data_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   int run_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Busy length, cleared while idle
   always_ff @(posedge clk or negedge rst_b)
      run_q <= !rst_b ? 0 : busy ? run_q + 1 : 0;
   a_oe_select: assert property (
      $past(rst_b, 2) |-> data_oe == {16{$past(!chip_select_n && !read_n, 2)}}) else $error("bad enable");
   a_start_busy: assert property (
      $fell(conversion_start_n) && !busy && !power_down_in && !reset_in |-> ##[1:4] busy) else $error("no start");
   // An abort by reset is the only short run allowed
   a_conv_len: assert property ($fell(busy) && !reset_in |-> run_q == `ACC_CONV_CYC) else $error("bad length");
   a_rst_abort: assert property (reset_in [*4] |-> !busy && config_out == 8'h00) else $error("no abort");
   a_rst_clear: assert property ($fell(reset_in) |-> ##[2:5] data_out == 16'h0000) else $error("no clear");
   a_pd_block: assert property (power_down_in [*4] ##0 !busy |=> !busy) else $error("start in power-down");
   a_sclk_gate: assert property (
      slave_sclk_gated |-> $past(serial_mode && !chip_select_n, 2)) else $error("clock not gated");
   a_range_pins: assert property (
      $past(rst_b, 2) |-> input_range == $past({range_polarity_select, range_span_select}, 2)) else $error("bad range");
   c_conv: cover property ($fell(busy));
   c_sclk: cover property (slave_sclk_gated);
   c_rst: cover property ($fell(reset_in));
endmodule
bind acc_conversion_control acc_checker u_acc_checker (.*);

/* tb/acc_host_model.sv */
// Host model that requests conversions
module acc_host_model (
   input  wire logic clk,
   output logic      conversion_start_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial conversion_start_n = 1'b1;
   // Held low four cycles so the synchroniser cannot miss it
   task automatic start();
      @(posedge clk) conversion_start_n <= 1'b0;
      repeat (4) @(posedge clk);
      conversion_start_n <= 1'b1;
   endtask
endmodule

/* tb/acc_conversion_control_test.sv */
// Self-checking bench for the conversion control block
module acc_conversion_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rst_b = 0, reset_in = 0, chip_select_n = 1, read_n = 1, power_down_in = 0;
   logic        serial_mode = 1, output_coding_select = 0, range_polarity_select = 1, range_span_select = 0;
   logic        slave_sclk = 0, cfg_sclk = 0, cfg_sdin = 0, conversion_start_n, sample_hold, busy;
   logic        powered_down, slave_sclk_gated;
   logic [1:0]  input_range;
   logic [7:0]  config_out;
   logic [15:0] result_in = 16'h35C3, data_out, data_oe;
   int          failures = 0, compares = 0, pulses = 0;
   acc_conversion_control u_acc_conversion_control (.*);
   acc_host_model u_acc_host_model (.clk(clk), .conversion_start_n(conversion_start_n));
   always #10 clk = ~clk;
   always @(posedge clk) pulses <= pulses + int'(slave_sclk_gated === 1'b1);
   task automatic tally_and_finish();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, e);
      compares++;
      failures += int'(g !== e);
      if (g !== e) $display("mismatch at %0t got %h exp %h", $time, g, e);
   endtask
   // Sign bit is flipped only when straight binary is off
   task automatic t_conv();
      for (int c = 0; c < 2; c++)
      begin
         @(posedge clk) output_coding_select <= c[0];
         u_acc_host_model.start();
         @(negedge clk) chk(16'(sample_hold), 16'h0001);
         repeat (205) @(negedge clk);
         chk(data_out, {~c[0], 15'h35C3});
      end
      chk(16'(input_range), 16'h0002);
      $display("t_conv done");
   endtask
   // Power-down mid-conversion still lets that one finish
   task automatic t_pd();
      @(posedge clk) result_in <= 16'h7E01;
      u_acc_host_model.start();
      @(posedge clk) power_down_in <= 1'b1;
      repeat (206) @(negedge clk);
      chk(data_out, 16'h7E01);
      u_acc_host_model.start();
      @(negedge clk) chk(16'(busy), 16'h0000);
      chk(16'(powered_down), 16'h0001);
      @(posedge clk) {chip_select_n, read_n} <= 2'b00;
      repeat (3) @(negedge clk);
      chk(data_oe, 16'hFFFF);
      @(posedge clk) {read_n, power_down_in} <= 2'b10;
      repeat (3) @(negedge clk);
      chk(data_oe, 16'h0000);
      $display("t_pd done");
   endtask
   task automatic t_serial(input logic cs, input int e);
      int p0;
      @(posedge clk) chip_select_n <= cs;
      repeat (3) @(posedge clk);
      p0 = pulses;
      repeat (8) @(posedge clk) slave_sclk <= ~slave_sclk;
      repeat (6) @(posedge clk);
      chk(16'(pulses - p0), 16'(e));
      $display("t_serial done");
   endtask
   // Config word loaded first so the clear can be seen
   task automatic t_reset();
      for (int s = 15; s >= 0; s--)
         @(posedge clk) {cfg_sdin, cfg_sclk} <= {1'(8'hA5 >> (s / 2)), 1'(s + 1)};
      repeat (4) @(negedge clk);
      chk(16'(config_out), 16'h00A5);
      u_acc_host_model.start();
      @(posedge clk) reset_in <= 1'b1;
      repeat (6) @(negedge clk);
      chk(16'(busy), 16'h0000);
      @(posedge clk) reset_in <= 1'b0;
      repeat (5) @(negedge clk);
      chk(data_out, 16'h0000);
      chk(16'(config_out), 16'h0000);
      $display("t_reset done");
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_conv();
      t_pd();
      t_serial(1'b0, 4);
      t_serial(1'b1, 0);
      t_reset();
      tally_and_finish();
   end
endmodule
